// ---- rtl/core_subset_exec.sv ----
// Execution unit for a subset of the 8-bit core instruction set
//
// Behaviour
// - Byte clear zeroes memory, flags untouched
// - Bit clear zeroes one bit only
// - Watchdog clear resets counter and both flags, but expiry in the same cycle still sets expired flag
// - Invert byte to memory or accumulator, Z only
// - Low nibble plus six if above nine/AC
// - High nibble plus six if above nine/C
// - Decimal adjust touches carry only, overflow sets
// - Minus one to memory or accumulator, Z only
// - Plus one to memory or accumulator, Z only
// - Sleep stops execution, keeps state, clears watchdog
// - Sleep sets sleep flag, clears expired flag unless expiry hits in the same cycle
// - Goto loads PC, two cycles, no flags
// - Copies move bytes, no flags affected
// - Idle only advances execution
// - Union ORs into accumulator or memory, Z only
// - Subroutine return pops PC, no flags
// - Return with value pops PC, loads accumulator
// - Interrupt return pops PC, sets global enable
// - Pending interrupt served before resuming main program
// - Rotate left in memory, bit7 to bit0
// - Rotate left into accumulator, memory unchanged
// - Rotate through carry, writes memory back
`timescale 1ns/100ps
module core_subset_exec #(
  parameter int MEM_DEPTH = core_subset_pkg::MEM_DEPTH_DEF,   // Data memory bytes
  parameter int PC_W      = core_subset_pkg::PC_W_DEF,        // Program counter width
  parameter int STACK_N   = core_subset_pkg::STACK_DEF,       // Return stack levels
  parameter int WDOG_W    = core_subset_pkg::WDOG_W_DEF,      // Watchdog counter width
  parameter int PRESC_W   = core_subset_pkg::PRESC_W_DEF,     // Watchdog prescaler width
  parameter logic [PC_W-1:0] IRQ_VEC = core_subset_pkg::IRQ_VEC_DEF // Interrupt entry
) (
  input  logic                          clk_sys_in,        // System clock, 25 MHz
  input  logic                          rstn_in,           // Async reset, active low
  input  logic                          ce_in,             // Clock enable, freezes all
  input  logic                          op_valid_in,       // Operation offered
  input  core_subset_pkg::op_t          op_code_in,        // Decoded operation
  input  logic [$clog2(MEM_DEPTH)-1:0]  op_addr_in,        // Data memory address
  input  logic [2:0]                    op_bit_in,         // Bit select
  input  logic [7:0]                    op_imm_in,         // Immediate operand
  input  logic [PC_W-1:0]               op_target_in,      // Goto destination
  input  logic                          push_in,           // Call logic pushes return
  input  logic [PC_W-1:0]               push_addr_in,      // Return address to push
  input  logic                          flag_wr_in,        // Load carry flags
  input  logic                          flag_c_in,         // Carry to load
  input  logic                          flag_ac_in,        // Aux carry to load
  input  logic                          irq_pending_in,    // Interrupt waiting
  input  logic                          wake_pin_in,       // Async wake-up pin
  input  logic [$clog2(MEM_DEPTH)-1:0]  peek_addr_in,      // Memory observe address
  output logic                          ready_out,         // Can take an operation
  output logic [7:0]                    accum_out,         // Accumulator
  output logic                          zero_flag_out,     // Z flag
  output logic                          carry_flag_out,    // C flag
  output logic                          aux_carry_out,     // AC flag
  output logic                          watchdog_expired_flag_out, // Watchdog expired
  output logic                          sleep_entered_flag_out,    // Sleep entered
  output logic                          global_irq_enable_out,     // Master irq enable
  output logic                          irq_ack_out,       // Pulse: irq entered
  output logic                          sys_clk_run_out,   // Low while clock stopped
  output logic [PC_W-1:0]               pc_out,            // Program counter
  output logic [WDOG_W-1:0]             watchdog_counter_out, // Watchdog count
  output logic [7:0]                    peek_data_out      // Memory observe data
);
  import core_subset_pkg::*;

  localparam int AW = $clog2(MEM_DEPTH);     // Memory address width
  localparam int SW = $clog2(STACK_N);       // Stack pointer width

  typedef enum logic [1:0] {st_run, st_dummy, st_sleep} state_t;

  state_t                 state;               // Sequencer state
  logic [7:0]             mem [MEM_DEPTH];     // Data memory in flip-flops
  logic [PC_W-1:0]        stack [STACK_N];     // Return stack
  logic [SW-1:0]          sp;                  // Next free stack slot
  logic [PRESC_W-1:0]     presc;               // Watchdog prescaler
  logic                   wake_meta;           // Wake synchroniser stage 1
  logic                   wake_sync;           // Wake synchroniser stage 2
  logic [DUMMY_CYC-1:0]   dummy_cnt;           // Dummy slot counter

  // Rotate one place left with a chosen fill bit
  function automatic logic [7:0] rot_left(input logic [7:0] v, input logic fill);
    rot_left = {v[MSB_BIT-1:LSB_BIT], fill};
  endfunction

  // Zero test shared by every Z-updating op
  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == ZERO_BYTE);
  endfunction

  // Operation accepted this cycle
  logic fire;
  assign fire = ce_in && op_valid_in && ready_out && (state == st_run);

  // Operand fetch
  logic [7:0] mval;
  assign mval = mem[op_addr_in];

  // Decimal correction terms; the high digit is judged after the low
  // correction, otherwise a digit carry such as 9a would be missed
  logic       bcd_lo_fix;    // Low digit needs six
  logic       bcd_hi_fix;    // High digit needs six
  logic [8:0] bcd_mid;       // Accumulator after low correction
  logic [8:0] bcd_sum;       // Fully corrected value with carry out
  assign bcd_lo_fix = (accum_out[NIB_W-1:0] > NIB_MAX) || aux_carry_out;
  assign bcd_mid    = {1'b0, accum_out} + {1'b0, (bcd_lo_fix ? BCD_LO : ZERO_BYTE)};
  assign bcd_hi_fix = (bcd_mid[DATA_W-1:NIB_W] > NIB_MAX) || bcd_mid[DATA_W] || carry_flag_out;
  assign bcd_sum    = bcd_mid + {1'b0, (bcd_hi_fix ? BCD_HI : ZERO_BYTE)};

  // Result steering
  logic [7:0] next_result;    // Value produced
  logic       next_to_mem;    // Write result to memory
  logic       next_to_acc;    // Write result to accumulator
  logic       next_z_upd;     // Z follows result
  always_comb begin
    next_result = ZERO_BYTE;
    next_to_mem = 1'b0;
    next_to_acc = 1'b0;
    next_z_upd  = 1'b0;
    case (op_code_in)
      clear_byte_op: begin
        next_result = ZERO_BYTE;
        next_to_mem = 1'b1;
      end
      clear_bit_op: begin
        next_result = mval & ~(ONE_BYTE << op_bit_in);
        next_to_mem = 1'b1;
      end
      invert_op, invert_to_accum_op: begin
        next_result = ~mval;
        next_to_mem = (op_code_in == invert_op);
        next_to_acc = (op_code_in == invert_to_accum_op);
        next_z_upd  = 1'b1;
      end
      bcd_adjust_op: begin
        next_result = bcd_sum[DATA_W-1:0];
        next_to_mem = 1'b1;
      end
      minus_one_op, minus_one_to_accum_op: begin
        next_result = mval - ONE_BYTE;
        next_to_mem = (op_code_in == minus_one_op);
        next_to_acc = (op_code_in == minus_one_to_accum_op);
        next_z_upd  = 1'b1;
      end
      plus_one_op, plus_one_to_accum_op: begin
        next_result = mval + ONE_BYTE;
        next_to_mem = (op_code_in == plus_one_op);
        next_to_acc = (op_code_in == plus_one_to_accum_op);
        next_z_upd  = 1'b1;
      end
      copy_to_accum_op: begin
        next_result = mval;
        next_to_acc = 1'b1;
      end
      copy_imm_op, back_from_sub_imm_op: begin
        next_result = op_imm_in;
        next_to_acc = 1'b1;
      end
      copy_to_mem_op: begin
        next_result = accum_out;
        next_to_mem = 1'b1;
      end
      union_op, union_imm_op, union_to_mem_op: begin
        next_result = accum_out | ((op_code_in == union_imm_op) ? op_imm_in : mval);
        next_to_mem = (op_code_in == union_to_mem_op);
        next_to_acc = (op_code_in != union_to_mem_op);
        next_z_upd  = 1'b1;
      end
      rotate_left_op, rotate_left_to_accum_op: begin
        next_result = rot_left(mval, mval[MSB_BIT]);
        next_to_mem = (op_code_in == rotate_left_op);
        next_to_acc = (op_code_in == rotate_left_to_accum_op);
      end
      rotate_left_thru_carry_op: begin
        next_result = rot_left(mval, carry_flag_out);
        next_to_mem = 1'b1;
      end
      default: begin
        // Idle, control flow other than return with value, and watchdog ops produce no byte
        next_result = ZERO_BYTE;
      end
    endcase
  end

  // Is the op one that ends with a dummy slot
  logic two_cycle;
  assign two_cycle = (op_code_in == goto_op) || (op_code_in == back_from_sub_op)
                  || (op_code_in == back_from_sub_imm_op) || (op_code_in == back_from_irq_op);

  // Wake pin synchroniser, second stage only is read
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wake_meta <= 1'b0;
      wake_sync <= 1'b0;
    end else if (ce_in) begin
      wake_meta <= wake_pin_in;
      wake_sync <= wake_meta;
    end
  end

  // Watchdog expiry term
  logic wdog_hit;
  assign wdog_hit = (presc == '1) && (watchdog_counter_out == '1);

  // Data memory writes; no reset so sleep and reset keep contents alike
  always_ff @(posedge clk_sys_in) begin
    if (fire && next_to_mem) begin
      mem[op_addr_in] <= next_result;
    end
  end

  // Observe port, registered
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      peek_data_out <= ZERO_BYTE;
    end else if (ce_in) begin
      peek_data_out <= mem[peek_addr_in];
    end
  end

  // Accumulator and zero flag
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      accum_out     <= ZERO_BYTE;
      zero_flag_out <= 1'b0;
    end else if (fire) begin
      if (next_to_acc) begin
        accum_out <= next_result;
      end
      if (next_z_upd) begin
        zero_flag_out <= is_zero(next_result);
      end
    end
  end

  // Carry and auxiliary carry
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      carry_flag_out <= 1'b0;
      aux_carry_out  <= 1'b0;
    end else if (ce_in) begin
      if (fire && op_code_in == bcd_adjust_op) begin
        // Over 99 shows as high fix or binary overflow
        carry_flag_out <= bcd_hi_fix || bcd_sum[DATA_W];
      end else if (fire && op_code_in == rotate_left_thru_carry_op) begin
        carry_flag_out <= mval[MSB_BIT];
      end else if (flag_wr_in) begin
        carry_flag_out <= flag_c_in;
        aux_carry_out  <= flag_ac_in;
      end
    end
  end

  // Sequencer: run, dummy slot, sleep
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state           <= st_run;
      ready_out       <= 1'b1;
      sys_clk_run_out <= 1'b1;
      dummy_cnt       <= '0;
    end else if (ce_in) begin
      case (state)
        st_run: begin
          if (fire && two_cycle) begin
            state     <= st_dummy;
            ready_out <= 1'b0;
            dummy_cnt <= '0;
          end else if (fire && op_code_in == sleep_op) begin
            state           <= st_sleep;
            ready_out       <= 1'b0;
            sys_clk_run_out <= 1'b0;
          end
        end
        st_dummy: begin
          if (dummy_cnt == DUMMY_CYC[DUMMY_CYC-1:0] - 1'b1) begin
            state     <= st_run;
            ready_out <= 1'b1;
          end else begin
            dummy_cnt <= dummy_cnt + 1'b1;
          end
        end
        st_sleep: begin
          // Wake pin or watchdog expiry restarts the clock
          if (wake_sync || wdog_hit) begin
            state           <= st_run;
            ready_out       <= 1'b1;
            sys_clk_run_out <= 1'b1;
          end
        end
        default: begin
          state     <= st_run;
          ready_out <= 1'b1;
        end
      endcase
    end
  end

  // Program counter, stack and interrupt entry
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pc_out                <= '0;
      sp                    <= '0;
      global_irq_enable_out <= 1'b0;
      irq_ack_out           <= 1'b0;
      for (int i = 0; i < STACK_N; i++) begin
        stack[i] <= '0;
      end
    end else if (ce_in) begin
      irq_ack_out <= 1'b0;
      if (fire) begin
        case (op_code_in)
          goto_op: pc_out <= op_target_in;
          back_from_sub_op, back_from_sub_imm_op: begin
            pc_out <= stack[sp - 1'b1];
            sp     <= sp - 1'b1;
          end
          back_from_irq_op: begin
            if (irq_pending_in) begin
              // Return address is not popped so the pending
              // handler returns to the main program afterwards
              pc_out                <= IRQ_VEC;
              irq_ack_out           <= 1'b1;
              global_irq_enable_out <= 1'b0;
            end else begin
              pc_out                <= stack[sp - 1'b1];
              sp                    <= sp - 1'b1;
              global_irq_enable_out <= 1'b1;
            end
          end
          sleep_op: pc_out <= pc_out + 1'b1;
          default:  pc_out <= pc_out + 1'b1;
        endcase
      end else if (push_in && state == st_run) begin
        stack[sp] <= push_addr_in;
        sp        <= sp + 1'b1;
      end
    end
  end

  // Watchdog counter, prescaler and its two flags
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      presc                     <= '0;
      watchdog_counter_out      <= '0;
      watchdog_expired_flag_out <= 1'b0;
      sleep_entered_flag_out    <= 1'b0;
    end else if (ce_in) begin
      if (fire && (op_code_in == clear_wdog_op || op_code_in == sleep_op)) begin
        presc                <= '0;
        watchdog_counter_out <= '0;
      end else begin
        presc <= presc + 1'b1;
        if (presc == '1) begin
          watchdog_counter_out <= watchdog_counter_out + 1'b1;
        end
      end
      if (fire && op_code_in == clear_wdog_op) begin
        sleep_entered_flag_out <= 1'b0;
      end else if (fire && op_code_in == sleep_op) begin
        sleep_entered_flag_out <= 1'b1;
      end
      // Expiry beats a same-cycle clear
      if (wdog_hit) begin
        watchdog_expired_flag_out <= 1'b1;
      end else if (fire && (op_code_in == clear_wdog_op || op_code_in == sleep_op)) begin
        watchdog_expired_flag_out <= 1'b0;
      end
    end
  end

  // Capture of the last accepted op for the checks below
  logic        chk_v;
  op_t         chk_op;
  logic [AW-1:0] chk_addr;
  logic [7:0]  chk_m, chk_a;
  logic        chk_c, chk_z;
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      chk_v    <= 1'b0;
      chk_op   <= idle_op;
      chk_addr <= '0;
      chk_m    <= ZERO_BYTE;
      chk_a    <= ZERO_BYTE;
      chk_c    <= 1'b0;
      chk_z    <= 1'b0;
    end else if (ce_in) begin
      chk_v    <= fire;
      chk_op   <= op_code_in;
      chk_addr <= op_addr_in;
      chk_m    <= mval;
      chk_a    <= accum_out;
      chk_c    <= carry_flag_out;
      chk_z    <= zero_flag_out;
    end
  end

  logic chk;
  assign chk = chk_v && ce_in && !wdog_hit;

  sequence s_goto_taken;
    fire && op_code_in == goto_op;
  endsequence
  sequence s_dummy_then_ready;
    !ready_out ##1 ready_out;
  endsequence

  a_clear_byte_zero: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    chk && chk_op == clear_byte_op |-> mem[chk_addr] == ZERO_BYTE && zero_flag_out == chk_z)
    else $error("byte clear left data or touched flags");
  a_clear_bit_only: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    fire && op_code_in == clear_bit_op |=> mem[$past(op_addr_in)]
      == ($past(mval) & ~(ONE_BYTE << $past(op_bit_in))))
    else $error("bit clear changed wrong bits");
  a_invert_acc_z: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    chk && chk_op == invert_to_accum_op |-> accum_out == ~chk_m && mem[chk_addr] == chk_m
      && zero_flag_out == (chk_m == 8'hff))
    else $error("invert to accumulator wrong");
  a_bcd_adjust_val: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    chk && chk_op == bcd_adjust_op && chk_a == 8'h9a && !chk_c |-> mem[chk_addr] == 8'h00 && carry_flag_out)
    else $error("decimal adjust of 9a not 00 with carry");
  a_plus_one_acc: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    chk && chk_op == plus_one_to_accum_op |-> accum_out == chk_m + ONE_BYTE && mem[chk_addr] == chk_m)
    else $error("plus one to accumulator wrong");
  a_minus_one_mem: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    chk && chk_op == minus_one_op |-> mem[chk_addr] == chk_m - ONE_BYTE && accum_out == chk_a)
    else $error("minus one to memory wrong");
  a_goto_two_cycle: assert property (@(posedge clk_sys_in) disable iff (!rstn_in || !ce_in)
    s_goto_taken |=> s_dummy_then_ready)
    else $error("goto did not take two cycles");
  a_sleep_flags: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    chk && chk_op == sleep_op |-> sleep_entered_flag_out && !watchdog_expired_flag_out
      && !sys_clk_run_out && watchdog_counter_out == '0)
    else $error("sleep entry flags wrong");
  a_rotate_carry: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    chk && chk_op == rotate_left_thru_carry_op |-> mem[chk_addr] == {chk_m[6:0], chk_c}
      && carry_flag_out == chk_m[MSB_BIT])
    else $error("rotate through carry wrong");
  a_irq_return_en: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    fire && op_code_in == back_from_irq_op && !irq_pending_in |=> global_irq_enable_out && !irq_ack_out)
    else $error("interrupt return did not re-enable");

endmodule

// ---- rtl/core_subset_pkg.sv ----
// Shared constants and operation codes for the core execution subset
package core_subset_pkg;

  localparam int        DATA_W     = 8;        // Byte width of data path
  localparam int        MSB_BIT    = 7;        // Top bit of a byte
  localparam int        LSB_BIT    = 0;        // Bottom bit of a byte
  localparam int        NIB_W      = 4;        // Nibble width
  localparam logic [7:0] ZERO_BYTE = 8'h00;    // Cleared byte value
  localparam logic [7:0] ONE_BYTE  = 8'h01;    // Step for plus and minus one
  localparam logic [3:0] NIB_MAX   = 4'h9;     // Largest legal decimal digit
  localparam logic [7:0] BCD_LO    = 8'h06;    // Low nibble decimal correction
  localparam logic [7:0] BCD_HI    = 8'h60;    // High nibble decimal correction

  // Timing: one system clock period and the dummy slot of a two-cycle op
  localparam int        CLK_PERIOD_NS = 40;    // 25 MHz system clock
  localparam int        DUMMY_NS      = 40;    // Dummy slot length
  localparam int        DUMMY_CYC     = (DUMMY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Default structural sizes
  localparam int        MEM_DEPTH_DEF = 64;    // Data memory bytes
  localparam int        PC_W_DEF      = 12;    // Program counter width
  localparam int        STACK_DEF     = 8;     // Return stack levels
  localparam int        WDOG_W_DEF    = 16;    // Watchdog counter width
  localparam int        PRESC_W_DEF   = 4;     // Watchdog prescaler width
  localparam logic [11:0] IRQ_VEC_DEF = 12'h004; // Interrupt entry address

  // Decoded operations handled by this block
  typedef enum logic [4:0] {
    idle_op, clear_byte_op, clear_bit_op, clear_wdog_op,
    invert_op, invert_to_accum_op, bcd_adjust_op,
    minus_one_op, minus_one_to_accum_op, plus_one_op, plus_one_to_accum_op,
    sleep_op, goto_op,
    copy_to_accum_op, copy_imm_op, copy_to_mem_op,
    union_op, union_imm_op, union_to_mem_op,
    back_from_sub_op, back_from_sub_imm_op, back_from_irq_op,
    rotate_left_op, rotate_left_to_accum_op, rotate_left_thru_carry_op
  } op_t;

endpackage

// ---- tb/testbench.sv ----
// Table-driven self-checking bench for the core execution subset
`timescale 1ns/100ps
module testbench;
  import core_subset_pkg::*;
  typedef struct {op_t op; logic [2:0] b; logic [7:0] imm, acc, mem; logic [1:0] zc;} row_t;
  logic        clk_sys = 1'b0, rstn = 1'b0;                 // Clock and reset
  logic        valid = 1'b0, push = 1'b0, irq = 1'b0, wake = 1'b0, ce = 1'b1; // Control
  logic        fwr = 1'b0, fc = 1'b0, fac = 1'b0;             // Carry flag loader
  op_t         code = idle_op;                                // Operation
  logic [11:0] tgt = 12'h000, paddr = 12'h000;                // Goto and push address
  logic [7:0]  imm = 8'h00;                                   // Immediate
  logic [2:0]  bsel = 3'h0;                                   // Bit select
  logic        ready, zf, cf, acf, wexp, slp, gie, ack, run;  // Status outputs
  logic [11:0] pc;                                            // Program counter
  logic [7:0]  accum, peek;                                   // Accumulator, memory view
  logic [3:0]  wdog;                                          // Shrunk watchdog count
  int          err_count = 0, checks_done = 0;                // Verdict counters
  // Byte at 0x05 walked through every data op but plus_one_to_accum_op; rows expect {z,c}
  row_t rows [23] = '{
    '{copy_to_mem_op, 3'h0, 8'h00, 8'h3c, 8'h3c, 2'h0}, '{invert_op, 3'h0, 8'h00, 8'h3c, 8'hc3, 2'h0},
    '{invert_to_accum_op, 3'h0, 8'h00, 8'h3c, 8'hc3, 2'h0}, '{plus_one_op, 3'h0, 8'h00, 8'h3c, 8'hc4, 2'h0},
    '{minus_one_to_accum_op, 3'h0, 8'h00, 8'hc3, 8'hc4, 2'h0}, '{clear_bit_op, 3'h2, 8'h00, 8'hc3, 8'hc0, 2'h0},
    '{rotate_left_op, 3'h0, 8'h00, 8'hc3, 8'h81, 2'h0}, '{rotate_left_to_accum_op, 3'h0, 8'h00, 8'h03, 8'h81, 2'h0},
    '{rotate_left_thru_carry_op, 3'h0, 8'h00, 8'h03, 8'h02, 2'h1},
    '{rotate_left_thru_carry_op, 3'h0, 8'h00, 8'h03, 8'h05, 2'h0},
    '{union_op, 3'h0, 8'h00, 8'h07, 8'h05, 2'h0}, '{union_to_mem_op, 3'h0, 8'h00, 8'h07, 8'h07, 2'h0},
    '{union_imm_op, 3'h0, 8'h00, 8'h07, 8'h07, 2'h0}, '{clear_byte_op, 3'h0, 8'h00, 8'h07, 8'h00, 2'h0},
    '{copy_to_accum_op, 3'h0, 8'h00, 8'h00, 8'h00, 2'h0}, '{minus_one_op, 3'h0, 8'h00, 8'h00, 8'hff, 2'h0},
    '{plus_one_op, 3'h0, 8'h00, 8'h00, 8'h00, 2'h2}, '{idle_op, 3'h0, 8'h00, 8'h00, 8'h00, 2'h2},
    '{copy_imm_op, 3'h0, 8'hff, 8'hff, 8'h00, 2'h2}, '{minus_one_to_accum_op, 3'h0, 8'h00, 8'hff, 8'h00, 2'h0},
    '{bcd_adjust_op, 3'h0, 8'h00, 8'hff, 8'h65, 2'h1}, '{copy_imm_op, 3'h0, 8'h45, 8'h45, 8'h65, 2'h1},
    '{bcd_adjust_op, 3'h0, 8'h00, 8'h45, 8'ha5, 2'h1}};
  // 25 MHz system clock
  always #20 clk_sys = ~clk_sys;
  // Small watchdog so expiry is reached in a few dozen cycles
  core_subset_exec #(.WDOG_W(4), .PRESC_W(1)) i_dut (
    .clk_sys_in(clk_sys), .rstn_in(rstn), .ce_in(ce), .op_valid_in(valid), .op_code_in(code),
    .op_addr_in(6'h05), .op_bit_in(bsel), .op_imm_in(imm), .op_target_in(tgt), .push_in(push),
    .push_addr_in(paddr), .flag_wr_in(fwr), .flag_c_in(fc), .flag_ac_in(fac), .irq_pending_in(irq),
    .wake_pin_in(wake), .peek_addr_in(6'h05), .ready_out(ready), .accum_out(accum), .zero_flag_out(zf),
    .carry_flag_out(cf), .aux_carry_out(acf), .watchdog_expired_flag_out(wexp), .sleep_entered_flag_out(slp),
    .global_irq_enable_out(gie), .irq_ack_out(ack), .sys_clk_run_out(run), .pc_out(pc),
    .watchdog_counter_out(wdog), .peek_data_out(peek));
  // Verdict and end of run
  task automatic complete_run();
    if (err_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Compare with four-state equality
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One offered op, held across its sampling edge, dropped after
  task automatic do_op(input op_t o, input logic [7:0] i, input logic [11:0] t);
    @(negedge clk_sys);
    code = o;
    imm = i;
    tgt = t;
    valid = 1'b1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    valid = 1'b0;
  endtask
  // Op plus result checks; memory view lags one cycle
  task automatic run_row(input row_t r);
    bsel = r.b;
    do_op(r.op, r.imm, 12'h000);
    chk({accum, zf, cf}, {r.acc, r.zc});
    @(negedge clk_sys);
    chk(peek, r.mem);
  endtask
  // Stand-in call pushes a return address
  task automatic push_ret(input logic [11:0] a);
    @(negedge clk_sys);
    {push, paddr} = {1'b1, a};
    @(negedge clk_sys);
    push = 1'b0;
  endtask
  // Bounded wait for ready (0) or watchdog expiry (1)
  task automatic wait_high(input bit sel);
    int n = 0;
    while ((sel ? wexp : ready) !== 1'b1 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    if ((sel ? wexp : ready) !== 1'b1) begin
      err_count++;
      complete_run();
    end
  endtask
  initial begin
    repeat (5) @(negedge clk_sys);
    chk({ready, run, gie, accum, pc}, {3'h6, 8'h00, 12'h000});
    rstn = 1'b1;
    do_op(copy_imm_op, 8'h3c, 12'h000);
    foreach (rows[k]) run_row(rows[k]);
    @(negedge clk_sys);
    {fwr, fc, fac} = 3'b101;
    @(negedge clk_sys);
    fwr = 1'b0;
    run_row('{copy_imm_op, 3'h0, 8'h12, 8'h12, 8'ha5, 2'h0});
    run_row('{bcd_adjust_op, 3'h0, 8'h00, 8'h12, 8'h18, 2'h0});
    do_op(goto_op, 8'h00, 12'h3a5);
    chk({ready, pc}, {1'b0, 12'h3a5});
    @(negedge clk_sys);
    chk(ready, 1'b1);
    push_ret(12'h123);
    do_op(back_from_sub_op, 8'h00, 12'h000);
    chk({pc, accum, cf, acf}, {12'h123, 8'h12, 2'b01});
    push_ret(12'h0ab);
    do_op(back_from_sub_imm_op, 8'h5a, 12'h000);
    chk({pc, accum}, {12'h0ab, 8'h5a});
    push_ret(12'h222);
    irq = 1'b1;
    do_op(back_from_irq_op, 8'h00, 12'h000);
    chk({pc, ack, gie}, {12'h004, 2'b10});
    irq = 1'b0;
    do_op(back_from_irq_op, 8'h00, 12'h000);
    chk({pc, gie}, {12'h222, 1'b1});
    do_op(sleep_op, 8'h00, 12'h000);
    chk({ready, run, slp, wexp, wdog}, {4'b0010, 4'h0});
    wake = 1'b1;
    wait_high(1'b0);
    wake = 1'b0;
    chk({peek, accum}, {8'h18, 8'h5a});
    wait_high(1'b1);
    do_op(clear_wdog_op, 8'h00, 12'h000);
    chk({wexp, slp, wdog}, {2'b00, 4'h0});
    run_row('{copy_imm_op, 3'h0, 8'h9a, 8'h9a, 8'h18, 2'h0});
    run_row('{bcd_adjust_op, 3'h0, 8'h00, 8'h9a, 8'h00, 2'h1});
    ce = 1'b0;
    do_op(plus_one_to_accum_op, 8'h00, 12'h000);
    chk({accum, zf, cf}, {8'h9a, 2'h1}); // Frozen while clock enable is low
    ce = 1'b1;
    complete_run();
  end
endmodule
